// [pmc_map.svh]
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
// register byte offsets
`define PMC_MODE_OFS      12'h000
`define PMC_ACT_TPL_OFS   12'h004
`define PMC_ALT_TPL_OFS   12'h008
`define PMC_STATUS_OFS    12'h00C
`define PMC_WAKE_EN_OFS   12'h010
// field positions
`define PMC_CPU_BIT       0
`define PMC_STAT_CPU_BIT  2
`define PMC_STAT_WAIT_BIT 3
// reset values
`define PMC_ACT_TPL_RST   32'hFFFF_FFFF
`define PMC_ALT_TPL_RST   32'h0000_0000
`define PMC_WAKE_EN_RST   32'h0000_003F
// timing
`define PMC_SLEEP_WAKE_NS 15000
`define PMC_HIB_WAKE_NS   100000
`define PMC_CLK_MHZ       100
`define PMC_SLEEP_WAKE_CYC ((`PMC_SLEEP_WAKE_NS * `PMC_CLK_MHZ) / 1000)
`define PMC_HIB_WAKE_CYC   ((`PMC_HIB_WAKE_NS * `PMC_CLK_MHZ) / 1000)
`endif

// [pmc_pkg.sv]
package pmc_pkg;
   typedef enum logic [1:0] {
      PMC_ACTIVE = 2'b00,
      PMC_ALT    = 2'b01,
      PMC_SLEEP  = 2'b10,
      PMC_HIB    = 2'b11
   } pmc_mode_t;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pmc_apb_req_t;
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } pmc_apb_rsp_t;
   // wakeup source vector: pins, timewheel, rtc, comparator, i2c, low voltage
   typedef struct packed {
      logic low_voltage_detect;
      logic i2c;
      logic comparator;
      logic rtc;
      logic central_timewheel;
      logic pin_interrupt_logic;
   } pmc_wake_t;
endpackage

// [pmc_sync.sv]
`timescale 1ns/10ps
// two-stage synchroniser, one per bit
module pmc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta;
         // first stage feeds only the second
         always_ff @(posedge clk) begin
            if (reset) begin
               meta <= 1'b0;
               q[i] <= 1'b0;
            end else begin
               meta <= d[i];
               q[i] <= meta;
            end
         end
      end
   endgenerate
endmodule // pmc_sync

// [pmc_ctrl.sv]
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "pmc_map.svh"
//
// Overview of operation
// - four modes ranked active, alternate active, sleep, hibernate.
// - after boot the controller is in active mode.
// - active template bits, writable any time, enable or disable resources.
// - a disabled resource has its digital clock gated off.
// - cpu may switch itself off; next wakeup turns it back on.
// - any enabled wakeup event forces the global mode to active; hibernate takes pin and reset events only.
// - a wakeup sets cpu_on whatever the template says; the cpu clock still needs its template bit.
// - alternate active uses its own template, like active mode.
// - sleep disables most resources; only low-speed clocks keep running.
// - leaving sleep returns to active within 15 us.
// - during the wake delay active entry is held off.
// - hibernate stops all clocks, keeps configuration and memory.
// - hibernate holds digital outputs and pin interrupt configuration.
// - only a pin interrupt or a device reset event wakes from hibernate.
// - hibernate wakeup resumes active within 100 us.
// - timewheel periodic interrupts act as wakeup events.
// - external, watchdog or precise voltage reset counts as wakeup.
module pmc_ctrl
   import pmc_pkg::*;
#(
   parameter int NRES       = 16,
   parameter int SLEEP_WAKE = `PMC_SLEEP_WAKE_CYC,
   parameter int HIB_WAKE   = `PMC_HIB_WAKE_CYC
) (
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire pmc_pkg::pmc_apb_req_t apb_req,
   output pmc_pkg::pmc_apb_rsp_t  apb_rsp,
   input  wire pmc_pkg::pmc_wake_t wake_in,
   input  wire logic              external_reset_pin_n,
   input  wire logic              watchdog_reset,
   input  wire logic              precise_voltage_reset,
   input  wire logic              cpu_off_req,
   output logic [NRES-1:0]        clk_gate_en,
   output logic                   low_speed_clk_en,
   output logic                   io_hold,
   output logic                   regulator_wait,
   output pmc_pkg::pmc_mode_t     mode
);
   import pmc_pkg::*;

   localparam int CW = $clog2(HIB_WAKE + 1);

   ////////////////////////////////////////////////////////////////////////
   // input synchronisation
   logic [8:0] raw_in;
   logic [8:0] sync_in;
   pmc_wake_t  wake_s;
   logic       reset_event;

   assign raw_in = {wake_in, ~external_reset_pin_n, watchdog_reset, precise_voltage_reset};

   pmc_sync #(.W(9)) u_sync (
      .clk   (clk),
      .reset (reset),
      .d     (raw_in),
      .q     (sync_in)
   );

   assign wake_s      = pmc_wake_t'(sync_in[8:3]);
   assign reset_event = |sync_in[2:0];

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [NRES-1:0] act_tpl;
   logic [NRES-1:0] alt_tpl;
   logic [5:0]      wake_en;
   logic            cpu_on;
   logic            waiting;
   logic [CW-1:0]   wait_cnt;
   logic            wr_stb;
   logic            rd_stb;
   logic            mode_wr;
   pmc_mode_t       req_mode;
   logic            wake_any;
   logic            wake_hib;

   assign wr_stb  = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign rd_stb  = apb_req.psel && apb_req.penable && !apb_req.pwrite;
   assign mode_wr = wr_stb && (apb_req.paddr == `PMC_MODE_OFS);
   assign req_mode = pmc_mode_t'(apb_req.pwdata[1:0]);

   // enabled sources plus device resets; timewheel is one of them
   assign wake_any = (|(wake_s & pmc_wake_t'(wake_en))) || reset_event;
   // hibernate leaves only on the pin interrupt logic or on a device reset event
   assign wake_hib = (wake_s.pin_interrupt_logic && wake_en[0]) || reset_event;

   // template registers, writable in any mode
   always_ff @(posedge clk) begin
      if (reset) begin
         act_tpl <= NRES'(`PMC_ACT_TPL_RST);
         alt_tpl <= NRES'(`PMC_ALT_TPL_RST);
         wake_en <= 6'(`PMC_WAKE_EN_RST);
      end else if (wr_stb) begin
         case (apb_req.paddr)
            `PMC_ACT_TPL_OFS: act_tpl <= apb_req.pwdata[NRES-1:0];
            `PMC_ALT_TPL_OFS: alt_tpl <= apb_req.pwdata[NRES-1:0];
            `PMC_WAKE_EN_OFS: wake_en <= apb_req.pwdata[5:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode state machine
   always_ff @(posedge clk) begin
      if (reset) begin
         mode <= PMC_ACTIVE;
      end else begin
         case (mode)
            PMC_ACTIVE, PMC_ALT: begin
               // low modes only by register write, never on our own
               if (mode_wr) begin
                  mode <= req_mode;
               end
               if (wake_any && mode == PMC_ALT) begin
                  mode <= PMC_ACTIVE;
               end
            end
            PMC_SLEEP: begin
               if (waiting && wait_cnt == CW'(1)) begin
                  mode <= PMC_ACTIVE;
               end
            end
            PMC_HIB: begin
               if (waiting && wait_cnt == CW'(1)) begin
                  mode <= PMC_ACTIVE;
               end
            end
            default: mode <= PMC_ACTIVE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // regulator settle delay after a low-mode wakeup
   always_ff @(posedge clk) begin
      if (reset) begin
         waiting  <= 1'b0;
         wait_cnt <= '0;
      end else if (waiting) begin
         wait_cnt <= wait_cnt - CW'(1);
         if (wait_cnt == CW'(1)) begin
            waiting <= 1'b0;
         end
      end else if (mode == PMC_SLEEP && wake_any) begin
         waiting  <= 1'b1;
         wait_cnt <= CW'(SLEEP_WAKE);
      end else if (mode == PMC_HIB && wake_hib) begin
         waiting  <= 1'b1;
         wait_cnt <= CW'(HIB_WAKE);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // cpu self switch-off; wakeup wins over a simultaneous off request
   always_ff @(posedge clk) begin
      if (reset) begin
         cpu_on <= 1'b1;
      end else if (wake_any || (waiting && wait_cnt == CW'(1))) begin
         cpu_on <= 1'b1;
      end else if (cpu_off_req) begin
         cpu_on <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock gates; sleep and hibernate override the templates
   logic [NRES-1:0] tpl_sel;
   always_comb begin
      case (mode)
         PMC_ACTIVE: tpl_sel = act_tpl;
         PMC_ALT:    tpl_sel = alt_tpl;
         default:    tpl_sel = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         clk_gate_en      <= '1;
         low_speed_clk_en <= 1'b1;
         io_hold          <= 1'b0;
         regulator_wait   <= 1'b0;
      end else begin
         // the cpu bit needs both the cpu state and its template bit
         clk_gate_en <= tpl_sel;
         clk_gate_en[`PMC_CPU_BIT] <= tpl_sel[`PMC_CPU_BIT] && cpu_on &&
                                      !(mode == PMC_SLEEP || mode == PMC_HIB);
         low_speed_clk_en <= (mode != PMC_HIB);
         io_hold          <= (mode == PMC_HIB);
         regulator_wait   <= waiting;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb response side for reads and writes: zero wait states
   always_comb begin
      apb_rsp.pready  = 1'b1;
      apb_rsp.pslverr = 1'b0;
      apb_rsp.prdata  = '0;
      if (rd_stb) begin
         case (apb_req.paddr)
            `PMC_MODE_OFS:    apb_rsp.prdata = {30'h0, mode};
            `PMC_ACT_TPL_OFS: apb_rsp.prdata = 32'(act_tpl);
            `PMC_ALT_TPL_OFS: apb_rsp.prdata = 32'(alt_tpl);
            `PMC_STATUS_OFS:  apb_rsp.prdata = {28'h0, waiting, cpu_on, mode};
            `PMC_WAKE_EN_OFS: apb_rsp.prdata = {26'h0, wake_en};
            default:          apb_rsp.pslverr = 1'b1;
         endcase
      end else if (wr_stb) begin
         case (apb_req.paddr)
            `PMC_MODE_OFS, `PMC_ACT_TPL_OFS, `PMC_ALT_TPL_OFS, `PMC_WAKE_EN_OFS:
               apb_rsp.pslverr = 1'b0;
            default: apb_rsp.pslverr = 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions

   // helper: cycles spent in a low mode since its wakeup was taken; the real wake
   // times are far too long for a delay range, so the bound is checked on a counter
   logic [CW:0] wake_age;
   always_ff @(posedge clk) begin
      if (reset || mode == PMC_ACTIVE || mode == PMC_ALT) begin
         wake_age <= '0;
      end else if (waiting || (mode == PMC_SLEEP && wake_any) || (mode == PMC_HIB && wake_hib)) begin
         // saturate so a stuck wake can never wrap back under the bound
         if (wake_age != '1) begin
            wake_age <= wake_age + (CW+1)'(1);
         end
      end
   end

   boot_active_a: assert property (@(posedge clk) $fell(reset) |-> mode == PMC_ACTIVE)
      else $error("mode not active after reset");
   sleep_wake_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_SLEEP) |-> wake_age <= (CW+1)'(SLEEP_WAKE))
      else $error("sleep wake too slow");
   hold_off_a: assert property (@(posedge clk) disable iff (reset)
      waiting |-> mode != PMC_ACTIVE)
      else $error("active entered during wake delay");
   hib_only_pin_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_HIB && !waiting && !wake_hib) |=> mode == PMC_HIB || waiting)
      else $error("hibernate left without pin");
   sleep_gate_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_SLEEP) |=> clk_gate_en == '0)
      else $error("clocks running in sleep");
   hib_hold_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_HIB) |=> io_hold && !low_speed_clk_en)
      else $error("hibernate not holding");
   cpu_wake_a: assert property (@(posedge clk) disable iff (reset)
      wake_any |=> cpu_on)
      else $error("cpu not enabled on wake");
   alt_wake_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_ALT && wake_any) |=> mode == PMC_ACTIVE)
      else $error("alt not returned to active");
   no_self_entry_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_ACTIVE && !mode_wr) |=> mode == PMC_ACTIVE)
      else $error("low mode entered without write");
   sleep_cov: cover property (@(posedge clk) mode == PMC_SLEEP && waiting ##1 mode == PMC_ACTIVE);
   hib_cov: cover property (@(posedge clk) mode == PMC_HIB && waiting);
   alt_cov: cover property (@(posedge clk) mode == PMC_ALT ##1 mode == PMC_ACTIVE);
   cpu_off_cov: cover property (@(posedge clk) cpu_on ##1 !cpu_on);

   // hibernate resume bound, on the same helper counter
   hib_wake_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_HIB)
      |-> wake_age <= (CW+1)'(HIB_WAKE))
      else $error("hibernate wake too slow");

   // cpu self switch-off and its clock gate
   cpu_off_a: assert property (@(posedge clk) disable iff (reset)
      (cpu_off_req && !wake_any && !(waiting && wait_cnt == CW'(1)))
      |=> !cpu_on)
      else $error("cpu did not switch off");
   cpu_gate_a: assert property (@(posedge clk) disable iff (reset)
      (!cpu_on)
      |=> !clk_gate_en[`PMC_CPU_BIT])
      else $error("cpu clock running while off");

   // templates drive the gates one clock later
   act_gate_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_ACTIVE)
      |=> clk_gate_en[NRES-1:1] == $past(act_tpl[NRES-1:1]))
      else $error("active gates not following template");
   alt_gate_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_ALT)
      |=> clk_gate_en[NRES-1:1] == $past(alt_tpl[NRES-1:1]))
      else $error("alternate gates not following template");

   // low modes override the templates
   hib_gate_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_HIB)
      |=> clk_gate_en == '0)
      else $error("clocks running in hibernate");
   sleep_lsc_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_SLEEP)
      |=> low_speed_clk_en)
      else $error("low speed clock stopped in sleep");

   // wake delay bookkeeping
   wait_cnt_a: assert property (@(posedge clk) disable iff (reset)
      waiting
      |-> wait_cnt != '0)
      else $error("wake delay counter empty");
   rw_follow_a: assert property (@(posedge clk) disable iff (reset)
      1'b1
      |=> regulator_wait == $past(waiting))
      else $error("regulator wait not following delay");
   sleep_exit_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_SLEEP && waiting && wait_cnt == CW'(1))
      |=> mode == PMC_ACTIVE)
      else $error("sleep not left at end of delay");
   hib_exit_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_HIB && waiting && wait_cnt == CW'(1))
      |=> mode == PMC_ACTIVE)
      else $error("hibernate not left at end of delay");

   // wake sources start the delay
   reset_wake_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_HIB && !waiting && reset_event)
      |=> waiting)
      else $error("device reset did not wake hibernate");
   tw_wake_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_SLEEP && !waiting && wake_s.central_timewheel && wake_en[1])
      |=> waiting)
      else $error("timewheel did not wake sleep");

   // mode entry by register write
   sleep_enter_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_ACTIVE && mode_wr && req_mode == PMC_SLEEP)
      |=> mode == PMC_SLEEP)
      else $error("sleep not entered on write");
   alt_enter_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_ACTIVE && mode_wr && req_mode == PMC_ALT)
      |=> mode == PMC_ALT)
      else $error("alternate not entered on write");
   hib_enter_a: assert property (@(posedge clk) disable iff (reset)
      (mode == PMC_ACTIVE && mode_wr && req_mode == PMC_HIB)
      |=> mode == PMC_HIB)
      else $error("hibernate not entered on write");
endmodule // pmc_ctrl

// [pmc_wake_src.sv]
`timescale 1ns/10ps
// wakeup sources; an event is held 4 clocks so the synchroniser cannot miss it
module pmc_wake_src (
   input  wire logic               clk,
   input  wire logic               go,
   input  wire pmc_pkg::pmc_wake_t pat,
   output pmc_pkg::pmc_wake_t      wake_in
);
   import pmc_pkg::*;
   logic [2:0] hold_cnt = 3'h0;
   pmc_wake_t  held     = '0;
   // latch the pattern on go and count the hold time down
   always_ff @(posedge clk) begin
      if (go) begin
         held     <= pat;
         hold_cnt <= 3'h4;
      end else if (hold_cnt != 3'h0) begin
         hold_cnt <= hold_cnt - 3'h1;
      end
   end
   // a released source is an idle active-high level, so it reads low
   assign wake_in = (hold_cnt != 3'h0) ? held : '0;
endmodule // pmc_wake_src

// [power_mode_controller_bench.sv]
`timescale 1ns/10ps
`include "pmc_map.svh"
module power_mode_controller_bench;
   import pmc_pkg::*;
   localparam int SW = 4;
   localparam int HW = 8;
   typedef struct {pmc_mode_t m; logic [5:0] w; int lo; int hi; int wt;} pmc_row_t;
   logic         clk = 0, reset = 1, wdog = 0, cpu_off = 0, go = 0, rerr, seen;
   pmc_wake_t    pat = '0, wake;
   pmc_apb_req_t req = '0;
   pmc_apb_rsp_t rsp;
   logic [15:0]  gate;
   logic         lsc, hold, rwait;
   pmc_mode_t    mode;
   logic [31:0]  rdata;
   int           n_fail = 0, num_checks = 0, cyc = 0, n;
   pmc_row_t     rows[6];
   // free-running clock
   always #5 clk = ~clk;
   pmc_ctrl #(.NRES(16), .SLEEP_WAKE(SW), .HIB_WAKE(HW)) i_pmc_ctrl (.clk(clk), .reset(reset),
      .apb_req(req), .apb_rsp(rsp), .wake_in(wake), .external_reset_pin_n(1'b1), .watchdog_reset(wdog),
      .precise_voltage_reset(1'b0), .cpu_off_req(cpu_off), .clk_gate_en(gate), .low_speed_clk_en(lsc),
      .io_hold(hold), .regulator_wait(rwait), .mode(mode));
   pmc_wake_src i_pmc_wake_src (.clk(clk), .go(go), .pat(pat), .wake_in(wake));
   ////////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
      end
   endtask
   task print_verdict;
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one apb transfer; request held until pready is seen at a rising edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk) req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk) req.penable <= 1'b1;
      @(posedge clk);
      while (rsp.pready !== 1'b1) @(posedge clk);
      rdata = rsp.prdata;
      rerr = rsp.pslverr;
      req <= '0;
   endtask
   task fire(input pmc_wake_t p);
      @(posedge clk) pat <= p;
      go <= 1'b1;
      @(posedge clk) go <= 1'b0;
   endtask
   // counts cycles until active, noting whether the regulator wait showed
   task wait_act(input int mx);
      n = 0;
      seen = 0;
      while (mode !== PMC_ACTIVE && n < mx) begin
         @(negedge clk);
         n++;
         if (rwait === 1'b1) seen = 1;
      end
   endtask
   task settle;
      repeat (3) @(negedge clk);
   endtask
   // a hang counts as a mismatch
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         print_verdict;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rows[0] = '{PMC_ALT, 6'h02, 1, 6, 0};
      rows[1] = '{PMC_SLEEP, 6'h04, SW, SW + 6, 1};
      rows[2] = '{PMC_SLEEP, 6'h08, SW, SW + 6, 1};
      rows[3] = '{PMC_SLEEP, 6'h10, SW, SW + 6, 1};
      rows[4] = '{PMC_SLEEP, 6'h20, SW, SW + 6, 1};
      rows[5] = '{PMC_HIB, 6'h01, HW, HW + 6, 2};
      repeat (5) @(posedge clk);
      reset <= 0;
      settle;
      chk("mode", PMC_ACTIVE, mode);
      chk("gate", 16'hFFFF, gate);
      chk("lsc", 1, {lsc, hold, rwait} == 3'h4);
      apb(0, `PMC_WAKE_EN_OFS, 0);
      chk("wake_en", `PMC_WAKE_EN_RST, rdata);
      apb(0, `PMC_ALT_TPL_OFS, 0);
      chk("alt_tpl", `PMC_ALT_TPL_RST, rdata);
      $display("reset test done");
      // template bits gate clocks; alternate active follows its own template
      apb(1, `PMC_ACT_TPL_OFS, 32'h0000_00F0);
      settle;
      chk("gate", 16'h00F0, gate);
      apb(1, `PMC_ALT_TPL_OFS, 32'h0000_0F0F);
      apb(1, `PMC_MODE_OFS, PMC_ALT);
      settle;
      chk("gate", 16'h0F0F, gate);
      apb(1, `PMC_ACT_TPL_OFS, 32'hFFFF_FFFF);
      fire(6'h01);
      wait_act(10);
      $display("template test done");
      // alternate active, sleep and hibernate, one wake source per row; each source used once
      foreach (rows[i]) begin
         apb(1, `PMC_MODE_OFS, rows[i].m);
         settle;
         chk("mode", rows[i].m, mode);
         chk("lsc", rows[i].m != PMC_HIB, lsc);
         chk("hold", rows[i].m == PMC_HIB, hold);
         fire(rows[i].w);
         wait_act(rows[i].hi + 4);
         chk("mode", PMC_ACTIVE, mode);
         chk("time", 1, n >= rows[i].lo && n <= rows[i].hi);
         if (rows[i].wt < 2) chk("wait", rows[i].wt, seen);
         repeat (8) @(negedge clk);
      end
      $display("wake table done");
      // cpu switches itself off, the next wake turns it back on
      @(posedge clk) cpu_off <= 1'b1;
      @(posedge clk) cpu_off <= 1'b0;
      settle;
      chk("cpu", 0, gate[0]);
      apb(0, `PMC_STATUS_OFS, 0);
      chk("cpu_on", 0, rdata[`PMC_STAT_CPU_BIT]);
      fire(6'h01);
      repeat (8) @(negedge clk);
      chk("cpu", 1, gate[0]);
      $display("cpu test done");
      // hibernate ignores every source but the pins; a reset still wakes
      apb(1, `PMC_MODE_OFS, PMC_HIB);
      fire(6'h3E);
      repeat (20) @(negedge clk);
      chk("mode", PMC_HIB, mode);
      @(posedge clk) wdog <= 1'b1;
      repeat (4) @(posedge clk);
      wdog <= 1'b0;
      wait_act(HW + 10);
      chk("mode", PMC_ACTIVE, mode);
      apb(1, 12'h020, 32'h1);
      chk("pslverr", 1, rerr);
      apb(0, 12'h020, 0);
      chk("pslverr", 1, rerr);
      $display("hibernate test done");
      // second reset from alternate active
      apb(1, `PMC_MODE_OFS, PMC_ALT);
      settle;
      chk("mode", PMC_ALT, mode);
      @(posedge clk) reset <= 1'b1;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      settle;
      chk("mode", PMC_ACTIVE, mode);
      $display("reset rerun done");
      print_verdict;
   end
endmodule // power_mode_controller_bench
